// [logic/lfs_consts.svh]
// constants for the led fault supervisor: offsets, bit positions, timing
// assumes a 20 MHz system clock and a 32-bit axi4-lite register bus
// Overview of operation
// [RULE1] cycle-by-cycle current limit sets no fault
// [RULE2] supply overcurrent: all channels off, recovery
// [RULE3] pump low: outputs off, flag, interrupt, retry
// [RULE4] bad pump capacitor: pump off, two flags
// [RULE5] config load check fail: flag, interrupt, keep running
// [RULE6] feedback above low limit: flag, inhibit switching
// [RULE7] low overvoltage only in soft-start or normal
// [RULE8] high overvoltage: flag, interrupt, recovery, retry
// [RULE9] feedback undervoltage 110 ms: overcurrent flag, recovery
// [RULE10] overcurrent watch starts with boost start
// [RULE11] bad channel resistor: four channels, 200 mA
// [RULE12] resistor checks latched only at initialization
// [RULE13] bad mode resistor: phase-shift, address 0x3a
// [RULE14] bad frequency resistors: 400 kHz, 305 Hz
// [RULE15] current pin shorted: code becomes one quarter
// [RULE16] current pin recovers: restore code; flag, interrupt
// [RULE17] overtemperature: outputs off until temperature falls
// [RULE18] raise boost; at maximum, open string disabled
// [RULE19] new lamp fault sets summary, interrupt
// [RULE20] string fault bits sticky; summary clearable
// [RULE21] over short threshold with one normal: short
// [RULE22] few groups, boost minimum, over headroom: short
// [RULE23] low overvoltage: no interrupt, no recovery
// [RULE24] inputs synchronised; timers count clock cycles
`ifndef LFS_CONSTS_SVH
`define LFS_CONSTS_SVH

// ****************************************
// timing
// ****************************************
`define LFS_CLK_HZ 20000000
`define LFS_RETRY_MS 100
`define LFS_UV_MS 110
`define LFS_RETRY_CYC (`LFS_RETRY_MS * (`LFS_CLK_HZ / 1000))
`define LFS_UV_CYC (`LFS_UV_MS * (`LFS_CLK_HZ / 1000))

// ****************************************
// register offsets
// ****************************************
`define LFS_ADR_FLAGS 6'h00
`define LFS_ADR_STRING 6'h01
`define LFS_ADR_CTRL 6'h02
`define LFS_ADR_CURRENT 6'h03
`define LFS_ADR_STATE 6'h04

// ****************************************
// flag bit positions and reset values
// ****************************************
`define LFS_F_PUMP 0
`define LFS_F_PCAP 1
`define LFS_F_CFGCHK 2
`define LFS_F_OVPL 3
`define LFS_F_OVPH 4
`define LFS_F_OCP 5
`define LFS_F_CHCFG 6
`define LFS_F_MODE 7
`define LFS_F_FSET 8
`define LFS_F_CURRENT_SET_PIN 9
`define LFS_F_HOT 10
`define LFS_F_LAMP 11
`define LFS_INT_MASK 12'he37
`define LFS_CUR_RST 12'hfff
`define LFS_CTRL_RST 32'h00000001

// ****************************************
// configuration defaults
// ****************************************
`define LFS_DEF_CHAN 3'h4
`define LFS_DEF_MA 8'hc8
`define LFS_DEF_ADDR 7'h3a
`define LFS_DEF_BKHZ 12'h190
`define LFS_DEF_DHZ 16'h0131

`endif

// [logic/lfs_pkg.sv]
// types shared by the led fault supervisor
// assumes nothing of its surroundings
package lfs_pkg;

  typedef enum logic [1:0] {
    LFS_DIM_PHASE,
    LFS_DIM_HYBRID,
    LFS_DIM_DIRECT,
    LFS_DIM_SPARE
  } lfs_dim_t;

  typedef enum logic [2:0] {
    LFS_ST_INIT,
    LFS_ST_SOFT,
    LFS_ST_NORM,
    LFS_ST_RECOV,
    LFS_ST_HOT
  } lfs_state_t;

  typedef struct packed {
    logic supply_ocp;
    logic cbc_limit;
    logic pump_low;
    logic pcap_bad;
    logic fb_ovp_low;
    logic fb_ovp_high;
    logic sense_a_ovp;
    logic fb_uv;
    logic die_hot;
    logic current_set_pin_short;
    logic boost_at_max;
    logic boost_at_min;
    logic [3:0] below_head;
    logic [3:0] above_short;
    logic [3:0] in_window;
    logic [3:0] above_headhys;
  } lfs_cmp_t;

  typedef struct packed {
    logic [2:0] chan_n;
    logic [7:0] chan_ma;
    lfs_dim_t dim_mode;
    logic [6:0] bus_addr;
    logic [11:0] boost_khz;
    logic [15:0] dim_hz;
    logic grouped;
  } lfs_setup_t;

endpackage

// [logic/lfs_sync.sv]
// two-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level, not a multi-bit word
`timescale 1ns/100ps
module lfs_sync
  import lfs_pkg::*;
#(
  parameter int W = 1
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // levels
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_r <= '0;
      o_q <= '0;
    end
    else
    begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end

endmodule // lfs_sync

// [logic/lfs_timer.sv]
// persistence timer: expires after LIM cycles of continuous run
// assumes i_run comes from logic on the same clock
`timescale 1ns/100ps
module lfs_timer
  import lfs_pkg::*;
#(
  parameter int LIM = 16
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // control
  input wire logic i_run,
  output logic o_exp
);

  localparam int W = $clog2(LIM + 1);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  assign cnt_nxt = !i_run ? '0 :
                   (cnt_r == W'(LIM)) ? cnt_r : cnt_r + W'(1);

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_r <= '0;
      o_exp <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      o_exp <= i_run && (cnt_nxt == W'(LIM));
    end
  end

endmodule // lfs_timer

// [logic/lfs_supervisor.sv]
// led driver fault supervisor with an axi4-lite register slave
// comparator levels are asynchronous; setup checks come from the
// initialisation logic on the same clock and stay valid while init
`timescale 1ns/100ps
`include "lfs_consts.svh"
module lfs_supervisor
  import lfs_pkg::*;
#(
  parameter int RETRY_CYC = `LFS_RETRY_CYC,
  parameter int UV_CYC = `LFS_UV_CYC
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // comparators and initialisation checks
  input wire lfs_cmp_t i_cmp,
  input wire lfs_setup_t i_setup,
  input wire logic i_chan_ok,
  input wire logic i_mode_ok,
  input wire logic i_bfreq_ok,
  input wire logic i_dfreq_ok,
  input wire logic i_cfg_load_bad,
  input wire logic i_boost_ready,
  // power stage controls
  output logic o_boost_en,
  output logic o_pline_en,
  output logic o_pump_en,
  output logic o_switch_inhibit,
  output logic o_boost_raise,
  output logic [3:0] o_led_en,
  output logic [11:0] o_cur_code,
  output lfs_setup_t o_setup,
  output logic o_int,
  // axi4-lite write
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic adr_ok(input logic [5:0] a);
    adr_ok = (a <= `LFS_ADR_STATE);
  endfunction

  // ****************************************
  // synchronised comparators and timers
  // ****************************************
  logic [$bits(lfs_cmp_t)-1:0] cmp_q;
  lfs_cmp_t cmp_s;
  lfs_state_t st_r;
  lfs_state_t st_nxt;
  logic uv_exp;
  logic retry_exp;

  // [RULE24] synchronise comparator levels
  lfs_sync #(.W($bits(lfs_cmp_t))) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_d(i_cmp),
    .o_q(cmp_q)
  );
  assign cmp_s = lfs_cmp_t'(cmp_q);

  wire run_w = (st_r == LFS_ST_SOFT) || (st_r == LFS_ST_NORM);
  wire norm_w = (st_r == LFS_ST_NORM);

  // [RULE9] [RULE10] undervoltage persistence from boost start
  lfs_timer #(.LIM(UV_CYC)) u_uv (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_run(run_w && cmp_s.fb_uv),
    .o_exp(uv_exp)
  );

  // [RULE24] retry delay counted in clock cycles
  lfs_timer #(.LIM(RETRY_CYC)) u_retry (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_run(st_r == LFS_ST_RECOV),
    .o_exp(retry_exp)
  );

  // ****************************************
  // fault decode
  // ****************************************
  logic cfg_done_r;
  logic [3:0] led_act_r;
  logic [11:0] flags_r;
  logic [31:0] ctrl_r;
  logic [11:0] prog_r;
  logic [11:0] cur_r;
  logic open_type_r;
  logic short_type_r;
  logic [3:0] chan_fault_r;
  logic pump_off_r;

  // [RULE3] pump low while running
  wire pump_w = run_w && cmp_s.pump_low;
  // [RULE4] pump capacitor checked at initialisation
  wire pcap_w = (st_r == LFS_ST_INIT) && cmp_s.pcap_bad;
  // [RULE6] [RULE7] low overvoltage only in soft-start or normal
  wire ovpl_w = run_w && cmp_s.fb_ovp_low;
  // [RULE8] high overvoltage from feedback or output sense
  wire ovph_w = run_w && (cmp_s.fb_ovp_high || cmp_s.sense_a_ovp);
  // [RULE1] [RULE23] neither current limit nor low overvoltage trips
  // [RULE2] supply overcurrent trips as well
  wire trip_w = (run_w && cmp_s.supply_ocp) || pump_w || ovph_w || uv_exp;
  wire hot_w = cmp_s.die_hot && (st_r != LFS_ST_RECOV);
  wire cap_w = (st_r == LFS_ST_INIT) && !cfg_done_r;

  // [RULE18] open string at boost maximum
  wire [3:0] open_w = {4{norm_w && cmp_s.boost_at_max}} &
                      cmp_s.below_head & led_act_r;
  // [RULE21] short while another string sits in the window
  wire any_win_w = |(cmp_s.in_window & led_act_r);
  wire [3:0] sh_a_w = {4{norm_w && any_win_w}} & cmp_s.above_short;
  // [RULE22] grouped with one or two groups at boost minimum
  wire few_w = o_setup.grouped && (o_setup.chan_n <= 3'h2);
  wire [3:0] sh_b_w = {4{norm_w && few_w && cmp_s.boost_at_min}} &
                      cmp_s.above_headhys;
  wire [3:0] short_w = (sh_a_w | sh_b_w) & led_act_r;
  wire [3:0] new_w = open_w | short_w;
  wire [3:0] used_w = 4'((5'h1 << o_setup.chan_n) - 5'h1);

  // ****************************************
  // state machine
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      LFS_ST_INIT:
        st_nxt = pcap_w ? LFS_ST_RECOV :
                 hot_w ? LFS_ST_HOT : LFS_ST_SOFT;
      LFS_ST_SOFT:
        st_nxt = trip_w ? LFS_ST_RECOV :
                 hot_w ? LFS_ST_HOT :
                 i_boost_ready ? LFS_ST_NORM : LFS_ST_SOFT;
      LFS_ST_NORM:
        st_nxt = trip_w ? LFS_ST_RECOV :
                 hot_w ? LFS_ST_HOT : LFS_ST_NORM;
      // [RULE3] [RULE8] [RULE9] restart after retry delay
      LFS_ST_RECOV:
        st_nxt = retry_exp ? LFS_ST_INIT : LFS_ST_RECOV;
      // [RULE17] restart once the die has cooled
      LFS_ST_HOT:
        st_nxt = cmp_s.die_hot ? LFS_ST_HOT : LFS_ST_INIT;
      default:
        st_nxt = LFS_ST_INIT;
    endcase
  end

  wire run_nxt = (st_nxt == LFS_ST_SOFT) || (st_nxt == LFS_ST_NORM);

  // ****************************************
  // register bus decode
  // ****************************************
  logic [5:0] awidx_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  wire aw_hs = i_awvalid && o_awready;
  wire w_hs = i_wvalid && o_wready;
  wire ar_hs = i_arvalid && o_arready;
  wire wr_do = !o_awready && !o_wready && !bvalid_r;
  wire [31:0] wm_w = wdata_r & lane_mask(wstrb_r);
  wire wr_flags = wr_do && (awidx_r == `LFS_ADR_FLAGS);
  wire wr_ctrl = wr_do && (awidx_r == `LFS_ADR_CTRL);
  wire wr_cur = wr_do && (awidx_r == `LFS_ADR_CURRENT);
  wire [31:0] cmask_w = lane_mask(wstrb_r);
  wire lamp_int_en = ctrl_r[0];

  // [RULE20] only the summary and other flags are write-one-clear
  wire [11:0] clr_w = wr_flags ? wm_w[11:0] : 12'h000;
  logic [11:0] set_w;
  always_comb
  begin
    set_w = 12'h000;
    // [RULE3] [RULE4] pump flags
    set_w[`LFS_F_PUMP] = pump_w || pcap_w;
    set_w[`LFS_F_PCAP] = pcap_w;
    // [RULE5] [RULE11] [RULE13] [RULE14] initialisation checks
    set_w[`LFS_F_CFGCHK] = cap_w && i_cfg_load_bad;
    set_w[`LFS_F_CHCFG] = cap_w && !i_chan_ok;
    set_w[`LFS_F_MODE] = cap_w && !i_mode_ok;
    set_w[`LFS_F_FSET] = cap_w && !(i_bfreq_ok && i_dfreq_ok);
    // [RULE6] low overvoltage flag
    set_w[`LFS_F_OVPL] = ovpl_w;
    // [RULE8] high overvoltage flag
    set_w[`LFS_F_OVPH] = ovph_w;
    // [RULE9] persistent undervoltage flag
    set_w[`LFS_F_OCP] = uv_exp && run_w;
    // [RULE16] current pin fault flag
    set_w[`LFS_F_CURRENT_SET_PIN] = cmp_s.current_set_pin_short;
    // [RULE17] thermal flag
    set_w[`LFS_F_HOT] = cmp_s.die_hot;
    // [RULE19] any new lamp fault, including after a clear
    set_w[`LFS_F_LAMP] = |new_w;
  end
  wire [11:0] flags_nxt = (flags_r & ~clr_w) | set_w;
  wire [11:0] imask_w = `LFS_INT_MASK & {lamp_int_en, 11'h7ff};

  wire [5:0] aridx_w = i_araddr[7:2];
  logic [31:0] rd_w;
  always_comb
  begin
    case (aridx_w)
      `LFS_ADR_FLAGS: rd_w = {20'h00000, flags_r};
      `LFS_ADR_STRING:
        rd_w = {26'h0000000, short_type_r, open_type_r, chan_fault_r};
      `LFS_ADR_CTRL: rd_w = ctrl_r;
      `LFS_ADR_CURRENT: rd_w = {4'h0, cur_r, 4'h0, prog_r};
      `LFS_ADR_STATE: rd_w = {25'h0000000, led_act_r, st_r};
      default: rd_w = 32'h00000000;
    endcase
  end

  // ****************************************
  // axi4-lite handshakes
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      bvalid_r <= 1'b0;
      o_bresp <= 2'h0;
      awidx_r <= 6'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= 2'h0;
    end
    else
    begin
      if (aw_hs)
      begin
        awidx_r <= i_awaddr[7:2];
        o_awready <= 1'b0;
      end
      if (w_hs)
      begin
        wdata_r <= i_wdata;
        wstrb_r <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (wr_do)
      begin
        bvalid_r <= 1'b1;
        o_bresp <= adr_ok(awidx_r) ? 2'h0 : 2'h2;
      end
      if (bvalid_r && i_bready)
      begin
        bvalid_r <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
      if (ar_hs)
      begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata <= rd_w;
        o_rresp <= adr_ok(aridx_w) ? 2'h0 : 2'h2;
      end
      if (o_rvalid && i_rready)
      begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end
  assign o_bvalid = bvalid_r;

  // ****************************************
  // supervisor state and outputs
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_r <= LFS_ST_INIT;
      cfg_done_r <= 1'b0;
      o_setup <= '0;
      flags_r <= 12'h000;
      o_int <= 1'b0;
      ctrl_r <= `LFS_CTRL_RST;
      prog_r <= `LFS_CUR_RST;
      cur_r <= `LFS_CUR_RST;
      led_act_r <= 4'h0;
      open_type_r <= 1'b0;
      short_type_r <= 1'b0;
      chan_fault_r <= 4'h0;
      pump_off_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      flags_r <= flags_nxt;
      o_int <= |(flags_nxt & imask_w);
      if (wr_ctrl)
        ctrl_r <= {31'h00000000, (wm_w[0] | (ctrl_r[0] & ~cmask_w[0]))};
      if (wr_cur)
        prog_r <= (wm_w[11:0]) | (prog_r & ~cmask_w[11:0]);
      // [RULE15] [RULE16] quarter code while shorted, else programmed
      cur_r <= cmp_s.current_set_pin_short ? {2'h0, prog_r[11:2]} : prog_r;
      // [RULE12] latch the resistor checks once
      if (cap_w)
      begin
        cfg_done_r <= 1'b1;
        o_setup <= i_setup;
        // [RULE11] four channels at 200 mA
        if (!i_chan_ok)
        begin
          o_setup.chan_n <= `LFS_DEF_CHAN;
          o_setup.chan_ma <= `LFS_DEF_MA;
        end
        // [RULE13] phase-shift dimming at the default address
        if (!i_mode_ok)
        begin
          o_setup.dim_mode <= LFS_DIM_PHASE;
          o_setup.bus_addr <= `LFS_DEF_ADDR;
        end
        // [RULE14] default switching and dimming frequencies
        if (!i_bfreq_ok)
          o_setup.boost_khz <= `LFS_DEF_BKHZ;
        if (!i_dfreq_ok)
          o_setup.dim_hz <= `LFS_DEF_DHZ;
      end
      if (st_r == LFS_ST_INIT && !cfg_done_r)
        led_act_r <= 4'hf;
      else
        // [RULE18] [RULE21] drop faulty strings from the loop
        led_act_r <= led_act_r & used_w & ~new_w;
      // [RULE20] string fault detail stays until reset
      open_type_r <= open_type_r | (|open_w);
      short_type_r <= short_type_r | (|short_w);
      chan_fault_r <= chan_fault_r | new_w;
      // [RULE4] pump stays off after a bad capacitor check until a later initialisation finds the capacitor good
      if (st_r == LFS_ST_INIT)
        pump_off_r <= cmp_s.pcap_bad;
    end
  end

  // [RULE2] [RULE3] [RULE17] boost, power line and led enables off outside the running states
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_boost_en <= 1'b0;
      o_pline_en <= 1'b0;
      o_pump_en <= 1'b0;
      o_switch_inhibit <= 1'b0;
      o_boost_raise <= 1'b0;
      o_led_en <= 4'h0;
      o_cur_code <= `LFS_CUR_RST;
    end
    else
    begin
      o_boost_en <= run_nxt;
      o_pline_en <= run_nxt;
      o_pump_en <= !pump_off_r && !pcap_w;
      // [RULE6] pause switching above the low overvoltage limit
      o_switch_inhibit <= ovpl_w;
      // [RULE18] ask for more boost while a string still in the loop is low
      o_boost_raise <= norm_w && |(cmp_s.below_head & led_act_r);
      o_led_en <= run_nxt ? (led_act_r & used_w & ~new_w) : 4'h0;
      o_cur_code <= cur_r;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  chk_ocp_off: assert property ( // [RULE2]
    run_w && cmp_s.supply_ocp |=> st_r == LFS_ST_RECOV && o_led_en == 4'h0)
    else $error("supply overcurrent did not stop the channels");
  chk_pump_trip: assert property ( // [RULE3]
    pump_w |=> flags_r[`LFS_F_PUMP] && o_int && !o_boost_en)
    else $error("pump low not handled");
  chk_pcap_flags: assert property ( // [RULE4]
    pcap_w |=> flags_r[1:0] == 2'h3 && !o_pump_en ##1 !o_pump_en)
    else $error("capacitor fault flags or pump wrong");
  chk_ovpl_inhibit: assert property ( // [RULE6]
    ovpl_w |=> o_switch_inhibit && flags_r[`LFS_F_OVPL])
    else $error("low overvoltage did not inhibit switching");
  chk_ovpl_idle: assert property ( // [RULE7]
    !run_w |=> !o_switch_inhibit)
    else $error("inhibit outside soft-start or normal");
  chk_ovpl_quiet: assert property ( // [RULE23]
    norm_w && !trip_w && !hot_w |=> st_r == LFS_ST_NORM)
    else $error("normal state left without a trip");
  chk_uv_trip: assert property ( // [RULE9]
    run_w && uv_exp |=> flags_r[`LFS_F_OCP] && st_r == LFS_ST_RECOV)
    else $error("undervoltage timeout not handled");
  chk_retry_hold: assert property ( // [RULE8]
    st_r == LFS_ST_RECOV && !retry_exp |=> st_r == LFS_ST_RECOV)
    else $error("recovery left before the retry delay");
  chk_current_set_pin_quarter: assert property ( // [RULE15]
    cmp_s.current_set_pin_short |=> cur_r == {2'h0, $past(prog_r[11:2])})
    else $error("shorted current pin code not one quarter");
  chk_cfg_held: assert property ( // [RULE12]
    cfg_done_r |=> $stable(o_setup))
    else $error("setup changed after initialisation");
  chk_chan_sticky: assert property ( // [RULE20]
    1'b1 |=> (chan_fault_r & $past(chan_fault_r)) == $past(chan_fault_r))
    else $error("channel fault bit lost");
  chk_open_drop: assert property ( // [RULE18]
    |open_w |=> (led_act_r & $past(open_w)) == 4'h0)
    else $error("open string still in the loop");

  cov_recover: cover property (norm_w ##1 st_r == LFS_ST_RECOV);
  cov_hot: cover property (st_r == LFS_ST_HOT ##1 st_r == LFS_ST_INIT);
  cov_short: cover property (|short_w);
  cov_current_set_pin: cover property (cmp_s.current_set_pin_short ##1 !cmp_s.current_set_pin_short);

endmodule // lfs_supervisor

// [tb/lfs_host.sv]
// host model: axi4-lite master that reads and clears fault flags
// assumes one clock; the bench calls its tasks just after an edge
`timescale 1ns/100ps
module lfs_host
  import lfs_pkg::*;
(
  // clock
  input wire logic i_clk,
  // write channels
  output logic o_awvalid,
  input wire logic i_awready,
  output logic [7:0] o_awaddr,
  output logic o_wvalid,
  input wire logic i_wready,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  input wire logic i_bvalid,
  output logic o_bready,
  // read channels
  output logic o_arvalid,
  input wire logic i_arready,
  output logic [7:0] o_araddr,
  input wire logic i_rvalid,
  output logic o_rready,
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_rresp
);
  // ****************************************
  // bus cycles
  // ****************************************
  initial
  begin
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h0;
    {o_awaddr, o_araddr, o_wdata, o_wstrb} = '0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    bit dn;
    begin
      @(posedge i_clk);
      o_awvalid <= 1'b1;
      o_awaddr <= a;
      o_wvalid <= 1'b1;
      o_wdata <= d;
      o_wstrb <= 4'hf;
      o_bready <= 1'b1;
      dn = 1'b0;
      for (n = 0; n < 100 && !dn; n++)
      begin
        @(posedge i_clk);
        if (i_awready) o_awvalid <= 1'b0;
        if (i_wready) o_wvalid <= 1'b0;
        if (i_bvalid) o_bready <= 1'b0;
        if (i_bvalid) dn = 1'b1;
      end
      if (!dn) tb.timeout_hit();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    bit dn;
    begin
      @(posedge i_clk);
      o_arvalid <= 1'b1;
      o_araddr <= a;
      o_rready <= 1'b1;
      dn = 1'b0;
      for (n = 0; n < 100 && !dn; n++)
      begin
        @(posedge i_clk);
        if (i_arready) o_arvalid <= 1'b0;
        if (i_rvalid) o_rready <= 1'b0;
        if (i_rvalid) {dn, d, r} = {1'b1, i_rdata, i_rresp};
      end
      if (!dn) tb.timeout_hit();
    end
  endtask
endmodule // lfs_host

// [tb/tb.sv]
// bench: drives comparators and checks outputs and flag registers
// assumes the host model for bus cycles and a 20 MHz clock
`timescale 1ns/100ps
`include "lfs_consts.svh"
module tb;
  import lfs_pkg::*;
  localparam int RETRY = 20;
  localparam int UV = 22;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_bad = 1'b1;
  logic [3:0] okv = 4'h0;
  logic raise;
  lfs_cmp_t cmp = '0;
  lfs_setup_t su = '0;
  lfs_setup_t so, es;
  logic boost, pline, pump, inh, int_q;
  logic [3:0] led, ws;
  logic [11:0] cur, code;
  logic awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat, v;
  logic [1:0] rp, r;
  int mismatches = 0;
  int n_checks = 0;

  always #25 clk = ~clk;

  lfs_supervisor #(.RETRY_CYC(RETRY), .UV_CYC(UV)) dut (
    .i_ref_clk(clk), .i_resetn(rst_n), .i_cmp(cmp), .i_setup(su),
    .i_chan_ok(okv[0]), .i_mode_ok(okv[1]), .i_bfreq_ok(okv[2]),
    .i_dfreq_ok(okv[3]), .i_cfg_load_bad(cfg_bad), .i_boost_ready(1'b1),
    .o_boost_en(boost), .o_pline_en(pline), .o_pump_en(pump),
    .o_switch_inhibit(inh), .o_boost_raise(raise), .o_led_en(led),
    .o_cur_code(cur), .o_setup(so), .o_int(int_q),
    .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv),
    .o_wready(wrd), .i_wdata(wd), .i_wstrb(ws), .o_bvalid(bv),
    .i_bready(br), .o_bresp(), .i_arvalid(arv), .o_arready(arr),
    .i_araddr(ara), .o_rvalid(rv), .i_rready(rr), .o_rdata(rdat),
    .o_rresp(rp));

  lfs_host host (
    .i_clk(clk), .o_awvalid(awv), .i_awready(awr), .o_awaddr(awa),
    .o_wvalid(wv), .i_wready(wrd), .o_wdata(wd), .o_wstrb(ws),
    .i_bvalid(bv), .o_bready(br), .o_arvalid(arv), .i_arready(arr),
    .o_araddr(ara), .i_rvalid(rv), .o_rready(rr), .i_rdata(rdat),
    .i_rresp(rp));

  // ****************************************
  // checking helpers
  // ****************************************
  function automatic lfs_setup_t exp_setup(input lfs_setup_t s,
    input logic [3:0] k);
    lfs_setup_t e;
    begin
      e = s;
      if (!k[0])
      begin
        e.chan_n = `LFS_DEF_CHAN;
        e.chan_ma = `LFS_DEF_MA;
      end
      if (!k[1])
      begin
        e.dim_mode = LFS_DIM_PHASE;
        e.bus_addr = `LFS_DEF_ADDR;
      end
      if (!k[2])
        e.boost_khz = `LFS_DEF_BKHZ;
      if (!k[3])
        e.dim_hz = `LFS_DEF_DHZ;
      return e;
    end
  endfunction

  task automatic chk(input string nm, input logic [63:0] e, g);
    begin
      n_checks++;
      if (g !== e)
      begin
        mismatches++;
        $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    begin
      host.rd(a, v, r);
      chk("rdata", 64'(e), 64'(v));
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic final_report;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  task automatic timeout_hit;
    begin
      mismatches++;
      final_report();
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    void'($urandom(32'h2a79));
    su = lfs_setup_t'(49'({$urandom, $urandom}));
    code = 12'($urandom);
    okv = 4'($urandom);
    wt(10);
    rst_n <= 1'b1;
    wt(6);
    es = exp_setup(su, okv);
    chk("setup", 64'(es), 64'(so));
    chk("code", 64'(12'hfff), 64'(cur));
    chk("pump", 64'(1'b1), 64'(pump));
    rchk(8'h00, 32'({!(okv[2] && okv[3]), !okv[1], !okv[0], 6'h04}));
    chk("int", 64'(1'b1), 64'(int_q));
    chk("boost", 64'(1'b1), 64'(boost));
    rchk(8'h08, 32'h1);
    host.wr(8'h00, 32'h1c4);
    cfg_bad <= 1'b0;
    su <= ~su;
    wt(4);
    chk("int", 64'(1'b0), 64'(int_q));
    chk("setup", 64'(es), 64'(so));
    cmp.cbc_limit <= 1'b1;
    wt(6);
    rchk(8'h00, 32'h0);
    chk("boost", 64'(1'b1), 64'(boost));
    cmp.cbc_limit <= 1'b0;
    cmp.below_head <= 4'h1;
    wt(6);
    chk("raise", 64'(es.chan_n != 3'h0), 64'(raise));
    cmp.below_head <= 4'h0;
    cmp.fb_ovp_low <= 1'b1;
    wt(6);
    chk("inhibit", 64'(1'b1), 64'(inh));
    chk("int", 64'(1'b0), 64'(int_q));
    chk("boost", 64'(1'b1), 64'(boost));
    rchk(8'h00, 32'h8);
    cmp.fb_ovp_low <= 1'b0;
    wt(6);
    host.wr(8'h00, 32'h8);
    host.wr(8'h0c, 32'(code));
    cmp.current_set_pin_short <= 1'b1;
    wt(6);
    chk("code", 64'(code >> 2), 64'(cur));
    cmp.current_set_pin_short <= 1'b0;
    wt(6);
    chk("code", 64'(code), 64'(cur));
    rchk(8'h00, 32'h200);
    chk("int", 64'(1'b1), 64'(int_q));
    host.wr(8'h00, 32'h200);
    cmp.pump_low <= 1'b1;
    wt(6);
    chk("enables", 64'(0), 64'({boost, pline, led}));
    rchk(8'h00, 32'h1);
    chk("int", 64'(1'b1), 64'(int_q));
    cmp.pump_low <= 1'b0;
    wt(4);
    host.wr(8'h00, 32'h1);
    wt(RETRY + 6);
    chk("boost", 64'(1'b1), 64'(boost));
    cmp.fb_uv <= 1'b1;
    wt(UV - 8);
    chk("boost", 64'(1'b1), 64'(boost));
    wt(14);
    chk("boost", 64'(1'b0), 64'(boost));
    rchk(8'h00, 32'h20);
    cmp.fb_uv <= 1'b0;
    host.rd(8'h40, v, r);
    chk("resp", 64'(2'b10), 64'(r));
    host.wr(8'h00, 32'h20);
    wt(RETRY + 6);
    chk("boost", 64'(1'b1), 64'(boost));
    cmp.die_hot <= 1'b1;
    wt(6);
    chk("enables", 64'(0), 64'({boost, pline, led}));
    rchk(8'h00, 32'h400);
    cmp.die_hot <= 1'b0;
    wt(6);
    chk("boost", 64'(1'b1), 64'(boost));
    final_report();
  end
endmodule // tb
